// File: core/fci_pkg.sv
// Constants shared by the four-channel filtered input block
package fci_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;            // 100 MHz system clock
  localparam int US_NS         = 1000;          // One microsecond in ns
  localparam int US_DIV        = US_NS / CLK_PERIOD_NS;
  localparam int TICKER_W      = 32;            // Microsecond ticker width
  localparam int NCH           = 4;             // Input channels

  // Filter times in ns, as selected by the delay codes
  localparam int FLT_2US_NS    = 2000;
  localparam int FLT_4US_NS    = 4000;
  localparam int FLT_12US_NS   = 12000;
  localparam int FLT_86US_NS   = 86000;
  localparam int FLT_342US_NS  = 342000;
  localparam int FLT_2731US_NS = 2731000;
  // Least times, rounded up to whole cycles
  localparam int FLT_2US_CYC    = (FLT_2US_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int FLT_4US_CYC    = (FLT_4US_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int FLT_12US_CYC   = (FLT_12US_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int FLT_86US_CYC   = (FLT_86US_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int FLT_342US_CYC  = (FLT_342US_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int FLT_2731US_CYC = (FLT_2731US_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int FLT_CNT_W      = 20;           // Holds the longest count

  // Filter delay codes
  localparam logic [7:0] DLY_2US    = 8'h00;
  localparam logic [7:0] DLY_4US    = 8'h02;
  localparam logic [7:0] DLY_12US   = 8'h04;
  localparam logic [7:0] DLY_86US   = 8'h07;
  localparam logic [7:0] DLY_342US  = 8'h09;
  localparam logic [7:0] DLY_2731US = 8'h0c;

  // Diagnostic enable codes
  localparam logic [7:0] DIAGNOSTIC_ENABLE_OFF = 8'h00;
  localparam logic [7:0] DIAGNOSTIC_ENABLE_ON  = 8'h40;

  // Reset values of parameter bytes
  localparam logic [7:0] DIAGNOSTIC_ENABLE_RST = 8'h00;
  localparam logic [7:0] DLY_RST     = 8'h02;
  localparam logic [3:0] EDGE_EN_RST = 4'h0;

  // Record numbers
  localparam logic [7:0] REC_PARAM0   = 8'h00;  // Diag enable / short diag
  localparam logic [7:0] REC_PARAM1   = 8'h01;  // Delays / full diag
  localparam logic [7:0] REC_EDGE     = 8'h80;  // Edge enables
  localparam logic [7:0] REC_PROC_IRQ = 8'hf0;  // Process interrupt data

  // Byte positions inside records
  localparam logic [4:0] EB_RISE      = 5'h00;
  localparam logic [4:0] EB_FALL      = 5'h01;
  localparam logic [4:0] PB_CAUSE     = 5'h00;
  localparam logic [4:0] PB_SNAP      = 5'h01;
  localparam logic [4:0] PB_TS_HI     = 5'h02;  // Subindex 04h
  localparam logic [4:0] PB_TS_LO     = 5'h03;  // Subindex 05h
  localparam logic [4:0] DB_ERR_A     = 5'h00;
  localparam logic [4:0] DB_MODINFO   = 5'h01;
  localparam logic [4:0] DB_SPARE     = 5'h02;
  localparam logic [4:0] DB_ERR_D     = 5'h03;
  localparam logic [4:0] DB_CHKIND    = 5'h04;
  localparam logic [4:0] DB_DIAG_BITS_PER_CHANNEL    = 5'h05;
  localparam logic [4:0] DB_CHCOUNT   = 5'h06;
  localparam logic [4:0] DB_CHLOST    = 5'h07;
  localparam logic [4:0] DB_TS0       = 5'h10;  // Ticker bytes 16..19
  localparam logic [4:0] DIAG_LEN     = 5'h14;  // Full record, 20 bytes
  localparam logic [4:0] DIAG_SHORT   = 5'h04;  // Short record, 4 bytes

  // Fixed descriptor bytes
  localparam logic [7:0] MODINFO_VAL  = 8'h1f;
  localparam logic [7:0] CHKIND_VAL   = 8'h70;
  localparam logic [7:0] DIAG_BITS_PER_CHANNEL_VAL   = 8'h00;
  localparam logic [7:0] CHCOUNT_VAL  = 8'h04;

  // Error bit positions
  localparam int ERRA_MOD_FAIL = 0;
  localparam int ERRA_EXT_ERR  = 2;
  localparam int ERRA_CH_ERR   = 3;
  localparam int ERRD_OVF      = 3;
  localparam int ERRD_PI_LOST  = 6;
endpackage : fci_pkg

// File: core/fci_top.sv
// Four-channel filtered digital input with process and diagnostic events
//
// Summary of operation
// - Diagnostics on only at 40h, off at 00h
// - Delay codes select 2 to 2731 us filters
// - Rising enable bits 0-3 per channel
// - Falling enable bits 0-3 per channel
// - Edges process irq; overflow, loss diagnostic
// - CANopen mode sends process data as emergency
// - Cause byte marks channels with edge
// - Snapshot filtered inputs at process interrupt
// - Free 32-bit microsecond ticker from zero, wraps
// - Low 16 ticker bits, high byte first
// - Enabled diagnostic cause raises incoming event
// - Going event once cause has gone
// - Channel events dropped during diagnostic window
// - Module fault on throughout diagnostic window
// - Record 01h full, record 00h four bytes
// - Fixed descriptors 1Fh, 70h, 00h, 04h
// - Error byte A: failure, external, channel
// - Error byte D: overflow bit 3, lost 6
// - Diagnostic timestamp holds full ticker
`timescale 1ns/1ps
`default_nettype none
module fci_top #(
  parameter int FLT_86US_CYC   = fci_pkg::FLT_86US_CYC,
  parameter int FLT_342US_CYC  = fci_pkg::FLT_342US_CYC,
  parameter int FLT_2731US_CYC = fci_pkg::FLT_2731US_CYC
) (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RESET,
  // Field inputs, asynchronous
  input  wire logic [3:0] INPUT_CHANNEL,
  // Filtered input state
  output logic [3:0]      IN_STATE,
  // Record access from the backplane
  input  wire logic [7:0] REC_NUM,
  input  wire logic [4:0] REC_BYTE,
  input  wire logic       REC_WR,
  input  wire logic [7:0] REC_WDATA,
  input  wire logic       REC_RD,
  output logic [7:0]      REC_RDATA,
  output logic            REC_RVALID,
  output logic            REC_ERR,
  // Process interrupt delivery
  input  wire logic       CANOPEN_SEL,
  input  wire logic       PIRQ_ACK,
  output logic            PIRQ_REQ,
  output logic            PIRQ_EMCY,
  output logic [31:0]     PIRQ_DATA,
  // Diagnostic events
  output logic            DIAG_INCOMING,
  output logic            DIAG_GOING,
  output logic            MODULE_FAULT_INDICATOR
);
  import fci_pkg::*;

  // All state below lives on CLOCK; only the field inputs cross domains,
  // and they pass the per-channel synchronisers before any use.

  // Parameter bytes
  logic [7:0]            diagnostic_enable_q;       // Raw enable byte
  logic [7:0]            channel_filter_delay_q [NCH]; // Delay codes
  logic [3:0]            rising_edge_irq_enable_q;  // Rising enables
  logic [3:0]            falling_edge_irq_enable_q; // Falling enables
  // Time base
  logic [6:0]            us_div_q;                  // Cycle divider
  logic                  us_tick;                   // One-cycle us pulse
  logic [TICKER_W-1:0]   ticker_q;                  // Microsecond ticker
  // Filter results
  logic [3:0]            filt_q;                    // Filtered levels
  logic [3:0]            filt_prev_q;               // Previous levels
  logic [3:0]            edge_evt;                  // Enabled edges
  // Process interrupt record
  logic                  pend_q;                    // Data awaits host
  logic [3:0]            irq_edge_cause_q;
  logic [3:0]            irq_input_snapshot_q;
  logic [15:0]           irq_timestamp_low16_q;
  // Diagnostic state
  logic                  pi_lost_q;                 // Process irq lost
  logic                  ovf_q;                     // Record overflow
  logic [3:0]            channel_edge_lost_q;
  logic                  diag_act_q;                // Window open
  logic [TICKER_W-1:0]   diag_timestamp_q;
  logic                  diag_on;
  logic                  diag_cause;
  logic                  slot_free;                 // May capture now
  logic                  loss;                      // Edge lost this cycle
  logic [7:0]            err_a;
  logic [7:0]            err_d;
  logic [7:0]            rd_mux;
  logic                  rd_ok;

  // Only the exact enable code turns diagnostics on
  assign diag_on = (diagnostic_enable_q == DIAGNOSTIC_ENABLE_ON);

  // Parameter writes; the host is trusted to write the enable in STOP
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      diagnostic_enable_q       <= DIAGNOSTIC_ENABLE_RST;
      rising_edge_irq_enable_q  <= EDGE_EN_RST;
      falling_edge_irq_enable_q <= EDGE_EN_RST;
      for (int i = 0; i < NCH; i++) begin
        channel_filter_delay_q[i] <= DLY_RST;
      end
    end else if (REC_WR) begin
      // Record 00h carries only the enable byte
      if (REC_NUM == REC_PARAM0 && REC_BYTE == 5'h00) begin
        diagnostic_enable_q <= REC_WDATA;
      end
      // Record 01h carries the four delay codes
      if (REC_NUM == REC_PARAM1 && REC_BYTE < 5'(NCH)) begin
        channel_filter_delay_q[REC_BYTE[1:0]] <= REC_WDATA;
      end
      // Reserved enable bits are not stored
      if (REC_NUM == REC_EDGE && REC_BYTE == EB_RISE) begin
        rising_edge_irq_enable_q <= REC_WDATA[3:0];
      end
      if (REC_NUM == REC_EDGE && REC_BYTE == EB_FALL) begin
        falling_edge_irq_enable_q <= REC_WDATA[3:0];
      end
    end
  end

  // Divider gives the one-microsecond enable
  // A pulse, not a derived clock, so the whole block stays on one clock
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      us_div_q <= 7'h00;
    end else if (us_div_q == 7'(US_DIV - 1)) begin
      us_div_q <= 7'h00;
    end else begin
      us_div_q <= us_div_q + 7'h01;
    end
  end
  assign us_tick = (us_div_q == 7'(US_DIV - 1));

  // Ticker starts at zero and wraps naturally past all ones
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ticker_q <= '0;
    end else if (us_tick) begin
      ticker_q <= ticker_q + 32'h00000001;
    end
  end

  // Delay code to cycle count; illegal codes fall back to 4 us
  function automatic logic [FLT_CNT_W-1:0] dly_cycles(input logic [7:0] c);
    unique case (c)
      DLY_2US:    dly_cycles = FLT_CNT_W'(FLT_2US_CYC);
      DLY_4US:    dly_cycles = FLT_CNT_W'(FLT_4US_CYC);
      DLY_12US:   dly_cycles = FLT_CNT_W'(FLT_12US_CYC);
      DLY_86US:   dly_cycles = FLT_CNT_W'(FLT_86US_CYC);
      DLY_342US:  dly_cycles = FLT_CNT_W'(FLT_342US_CYC);
      DLY_2731US: dly_cycles = FLT_CNT_W'(FLT_2731US_CYC);
      default:    dly_cycles = FLT_CNT_W'(FLT_4US_CYC);
    endcase
  endfunction : dly_cycles

  // Per-channel synchroniser and stability filter
  // Both edge directions use the same delay; a glitch shorter than the
  // delay restarts the count and never reaches the edge logic
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [2:0]           sync_q;  // Three-stage synchroniser
    logic [FLT_CNT_W-1:0] cnt_q;   // Stable-time counter
    logic [FLT_CNT_W-1:0] lim;     // Selected delay

    assign lim = dly_cycles(channel_filter_delay_q[g]);

    // Synchroniser chain; stage 0 is read only by stage 1
    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        sync_q <= 3'h0;
      end else begin
        sync_q <= {sync_q[1:0], INPUT_CHANNEL[g]};
      end
    end

    // New level counts only while sync_q[1] and sync_q[2] agree
    always_ff @(posedge CLOCK or posedge RESET) begin
      if (RESET) begin
        cnt_q     <= '0;
        filt_q[g] <= 1'b0;
      end else if (sync_q[1] != sync_q[2] || sync_q[2] == filt_q[g]) begin
        // Glitch or no change: restart the stability count
        cnt_q <= '0;
      end else if (cnt_q + 1'b1 >= lim) begin
        // Stable for the whole delay: accept the level
        cnt_q     <= '0;
        filt_q[g] <= sync_q[2];
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // Edge history on the filtered levels
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      filt_prev_q <= 4'h0;
    end else begin
      filt_prev_q <= filt_q;
    end
  end

  // Enabled edges per channel
  assign edge_evt = (filt_q & ~filt_prev_q & rising_edge_irq_enable_q)
                  | (~filt_q & filt_prev_q & falling_edge_irq_enable_q);

  // An acknowledge in the same cycle frees the slot for a new edge
  assign slot_free = !pend_q || PIRQ_ACK;
  // Edges inside the diagnostic window are simply dropped
  assign loss = !diag_act_q && (edge_evt != 4'h0) && !slot_free;

  // Process interrupt capture
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      pend_q                <= 1'b0;
      irq_edge_cause_q      <= 4'h0;
      irq_input_snapshot_q  <= 4'h0;
      irq_timestamp_low16_q <= 16'h0000;
    end else if (!diag_act_q && edge_evt != 4'h0 && slot_free) begin
      // New capture wins over an acknowledge in the same cycle
      pend_q                <= 1'b1;
      irq_edge_cause_q      <= edge_evt;
      irq_input_snapshot_q  <= filt_q;
      irq_timestamp_low16_q <= ticker_q[15:0];
    end else if (PIRQ_ACK) begin
      pend_q <= 1'b0;
    end
  end

  // Loss flags; a loss sets the lost flags, a loss while pi_lost_q is set also sets ovf_q; an acknowledge clears them
  // A loss cannot meet an acknowledge: the acknowledge frees the slot first
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      pi_lost_q           <= 1'b0;
      ovf_q               <= 1'b0;
      channel_edge_lost_q <= 4'h0;
    end else if (loss) begin
      pi_lost_q           <= 1'b1;
      ovf_q               <= ovf_q | pi_lost_q;
      channel_edge_lost_q <= channel_edge_lost_q | edge_evt;
    end else if (PIRQ_ACK) begin
      // Host has drained the pending data: causes are gone
      pi_lost_q           <= 1'b0;
      ovf_q               <= 1'b0;
      channel_edge_lost_q <= 4'h0;
    end
  end

  // Both causes are fixed diagnostics with no per-cause mask
  assign diag_cause = pi_lost_q || ovf_q;

  // Diagnostic window: incoming opens, going closes it
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      diag_act_q       <= 1'b0;
      DIAG_INCOMING    <= 1'b0;
      DIAG_GOING       <= 1'b0;
      diag_timestamp_q <= '0;
    end else begin
      DIAG_INCOMING <= 1'b0;
      DIAG_GOING    <= 1'b0;
      if (!diag_act_q && diag_on && diag_cause) begin
        diag_act_q       <= 1'b1;
        DIAG_INCOMING    <= 1'b1;
        diag_timestamp_q <= ticker_q;
      end else if (diag_act_q && (!diag_cause || !diag_on)) begin
        diag_act_q <= 1'b0;
        DIAG_GOING <= 1'b1;
      end
    end
  end

  // Fault indicator follows the open window
  assign MODULE_FAULT_INDICATOR = diag_act_q;

  // Error summary bytes
  always_comb begin
    err_a = 8'h00;
    err_a[ERRA_MOD_FAIL] = diag_act_q;
    err_a[ERRA_EXT_ERR]  = 1'b0;
    err_a[ERRA_CH_ERR]   = channel_edge_lost_q != 4'h0;
    err_d = 8'h00;
    err_d[ERRD_OVF]      = ovf_q;
    err_d[ERRD_PI_LOST]  = pi_lost_q;
  end

  // Read multiplexer over all readable records
  always_comb begin
    rd_mux = 8'h00;
    rd_ok  = 1'b1;
    if ((REC_NUM == REC_PARAM1 && REC_BYTE < DIAG_LEN)
        || (REC_NUM == REC_PARAM0 && REC_BYTE < DIAG_SHORT)) begin
      // Diagnostic record
      if (REC_BYTE >= DB_TS0) begin
        rd_mux = diag_timestamp_q[8*(REC_BYTE[1:0]) +: 8];
      end else begin
        unique case (REC_BYTE)
          DB_ERR_A:   rd_mux = err_a;
          DB_MODINFO: rd_mux = MODINFO_VAL;
          DB_SPARE:   rd_mux = 8'h00;
          DB_ERR_D:   rd_mux = err_d;
          DB_CHKIND:  rd_mux = CHKIND_VAL;
          DB_DIAG_BITS_PER_CHANNEL:  rd_mux = DIAG_BITS_PER_CHANNEL_VAL;
          DB_CHCOUNT: rd_mux = CHCOUNT_VAL;
          DB_CHLOST:  rd_mux = {4'h0, channel_edge_lost_q};
          default:    rd_mux = 8'h00; // Spare channel bytes
        endcase
      end
    end else if (REC_NUM == REC_EDGE && REC_BYTE == EB_RISE) begin
      rd_mux = {4'h0, rising_edge_irq_enable_q};
    end else if (REC_NUM == REC_EDGE && REC_BYTE == EB_FALL) begin
      rd_mux = {4'h0, falling_edge_irq_enable_q};
    end else if (REC_NUM == REC_PROC_IRQ && REC_BYTE <= PB_TS_LO) begin
      // Process interrupt record, timestamp high byte first
      unique case (REC_BYTE[1:0])
        PB_CAUSE[1:0]: rd_mux = {4'h0, irq_edge_cause_q};
        PB_SNAP[1:0]:  rd_mux = {4'h0, irq_input_snapshot_q};
        PB_TS_HI[1:0]: rd_mux = irq_timestamp_low16_q[15:8];
        PB_TS_LO[1:0]: rd_mux = irq_timestamp_low16_q[7:0];
      endcase
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read answer one cycle after the strobe; unknown places flag an error
  // Registering the data keeps it steady while the host picks it up
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      REC_RDATA  <= 8'h00;
      REC_RVALID <= 1'b0;
      REC_ERR    <= 1'b0;
    end else begin
      REC_RVALID <= REC_RD;
      REC_ERR    <= 1'b0;
      if (REC_RD) begin
        REC_RDATA <= rd_ok ? rd_mux : 8'h00;
        REC_ERR   <= !rd_ok;
      end else if (REC_WR) begin
        // Only parameter places take writes
        REC_ERR <= !((REC_NUM == REC_PARAM0 && REC_BYTE == 5'h00)
                  || (REC_NUM == REC_PARAM1 && REC_BYTE < 5'(NCH))
                  || (REC_NUM == REC_EDGE && REC_BYTE <= EB_FALL));
      end
    end
  end

  // Outgoing process data and input state registers
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      PIRQ_DATA <= 32'h00000000;
      IN_STATE  <= 4'h0;
    end else begin
      PIRQ_DATA <= {4'h0, irq_edge_cause_q, 4'h0, irq_input_snapshot_q,
                    irq_timestamp_low16_q};
      IN_STATE  <= filt_q;
    end
  end

  // Delivery path chosen by the backplane kind
  // Only one of the two requests is ever high for a pending record
  assign PIRQ_EMCY = pend_q && CANOPEN_SEL;
  assign PIRQ_REQ  = pend_q && !CANOPEN_SEL;
endmodule : fci_top
`default_nettype wire

// File: sim/fci_properties.sv
// Concurrent checks on the ports of the filtered input block
`timescale 1ns/1ps
`default_nettype none
module fci_checker (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RESET,
  // Record port
  input wire logic        REC_RD,
  input wire logic        REC_WR,
  input wire logic        REC_RVALID,
  input wire logic        REC_ERR,
  // Process interrupt delivery
  input wire logic        CANOPEN_SEL,
  input wire logic        PIRQ_ACK,
  input wire logic        PIRQ_REQ,
  input wire logic        PIRQ_EMCY,
  input wire logic [31:0] PIRQ_DATA,
  // Diagnostic events
  input wire logic        DIAG_INCOMING,
  input wire logic        DIAG_GOING,
  input wire logic        MODULE_FAULT_INDICATOR
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  // Either delivery path counts as pending
  logic pend;
  assign pend = PIRQ_REQ || PIRQ_EMCY;

  // A fresh capture starts
  sequence s_new_pend;
    !pend ##1 pend;
  endsequence
  // Pending with no acknowledge for three cycles
  sequence s_held;
    (pend && !PIRQ_ACK)[*3];
  endsequence

  rd_answer_a: assert property (REC_RD |=> REC_RVALID)
    else $error("read strobe got no valid answer");
  err_cause_a: assert property (REC_ERR |-> $past(REC_RD || REC_WR))
    else $error("error pulse without a strobe");
  path_sel_a: assert property (pend |-> PIRQ_EMCY == CANOPEN_SEL)
    else $error("delivery path does not follow selection");
  cause_data_a: assert property (s_new_pend |=>
    PIRQ_DATA[31:28] == 4'h0 && PIRQ_DATA[27:24] != 4'h0)
    else $error("cause byte empty or reserved bits set");
  data_hold_a: assert property (s_held |-> $stable(PIRQ_DATA))
    else $error("pending data overwritten");
  in_pulse_a: assert property (DIAG_INCOMING |=> !DIAG_INCOMING)
    else $error("incoming event longer than one cycle");
  in_fault_a: assert property (DIAG_INCOMING |-> MODULE_FAULT_INDICATOR)
    else $error("incoming event without fault indicator");
  fault_rise_a: assert property ($rose(MODULE_FAULT_INDICATOR) |->
    DIAG_INCOMING)
    else $error("fault indicator rose without incoming event");
  fault_fall_a: assert property ($fell(MODULE_FAULT_INDICATOR) |->
    DIAG_GOING)
    else $error("fault indicator fell without going event");
  go_fault_a: assert property (DIAG_GOING |->
    !MODULE_FAULT_INDICATOR && $past(MODULE_FAULT_INDICATOR))
    else $error("going event outside a fault window");
endmodule : fci_checker

bind fci_top fci_checker i_chk (
  .CLOCK(CLOCK), .RESET(RESET), .REC_RD(REC_RD), .REC_WR(REC_WR),
  .REC_RVALID(REC_RVALID), .REC_ERR(REC_ERR), .CANOPEN_SEL(CANOPEN_SEL),
  .PIRQ_ACK(PIRQ_ACK), .PIRQ_REQ(PIRQ_REQ), .PIRQ_EMCY(PIRQ_EMCY),
  .PIRQ_DATA(PIRQ_DATA), .DIAG_INCOMING(DIAG_INCOMING),
  .DIAG_GOING(DIAG_GOING), .MODULE_FAULT_INDICATOR(MODULE_FAULT_INDICATOR)
);
`default_nettype wire

// File: sim/fci_host_model.sv
// Host model issuing record accesses and interrupt acknowledges
`timescale 1ns/1ps
`default_nettype none
module fci_host_model (
  // Clock
  input  wire logic       clk,
  // Record port toward the block
  output var logic [7:0]  rec_num,
  output var logic [4:0]  rec_byte,
  output var logic        rec_wr,
  output var logic [7:0]  rec_wdata,
  output var logic        rec_rd,
  input  wire logic [7:0] rec_rdata,
  input  wire logic       rec_rvalid,
  input  wire logic       rec_err,
  // Interrupt acknowledge
  output var logic        pirq_ack
);
  // Idle bus at time zero
  initial begin
    rec_num = 8'h00;
    rec_byte = 5'h00;
    rec_wr = 1'b0;
    rec_wdata = 8'h00;
    rec_rd = 1'b0;
    pirq_ack = 1'b0;
  end

  // One write; codes pass unchanged, callers keep them legal
  task automatic wr(input logic [7:0] n, input logic [4:0] b,
                    input logic [7:0] d);
    @(negedge clk);
    rec_num = n;
    rec_byte = b;
    rec_wdata = d;
    rec_wr = 1'b1;
    @(negedge clk);
    rec_wr = 1'b0;
  endtask : wr

  // One read; answer is taken one cycle after the strobe
  task automatic rd(input logic [7:0] n, input logic [4:0] b,
                    output logic [7:0] d, output logic e);
    @(negedge clk);
    rec_num = n;
    rec_byte = b;
    rec_rd = 1'b1;
    @(negedge clk);
    d = rec_rvalid ? rec_rdata : 8'hxx;
    e = rec_err;
    rec_rd = 1'b0;
  endtask : rd

  // Process data taken
  task automatic ack;
    @(negedge clk);
    pirq_ack = 1'b1;
    @(negedge clk);
    pirq_ack = 1'b0;
  endtask : ack
endmodule : fci_host_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the filtered input block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fci_pkg::*;
  // Shortened long filter counts
  localparam int L86   = 20;
  localparam int L342  = 40;
  localparam int L2731 = 80;
  // Stimulus and observed signals
  logic        clock;
  logic        reset;
  logic [3:0]  in_ch;
  logic        co_sel;
  logic [7:0]  rec_num, rec_wdata, rec_rdata, d, lo;
  logic [4:0]  rec_byte;
  logic        rec_wr, rec_rd, rec_rvalid, rec_err, pirq_ack, e;
  logic        pirq_req, pirq_emcy, diag_in, diag_go, fault;
  logic [31:0] pirq_data;
  logic [3:0]  in_state;
  int          fails = 0, tests_run = 0, cyc = 0, n_in = 0, n_go = 0;

  fci_top #(.FLT_86US_CYC(L86), .FLT_342US_CYC(L342),
    .FLT_2731US_CYC(L2731)) i_dut (
    .CLOCK(clock), .RESET(reset), .INPUT_CHANNEL(in_ch),
    .IN_STATE(in_state), .REC_NUM(rec_num), .REC_BYTE(rec_byte),
    .REC_WR(rec_wr), .REC_WDATA(rec_wdata), .REC_RD(rec_rd),
    .REC_RDATA(rec_rdata), .REC_RVALID(rec_rvalid), .REC_ERR(rec_err),
    .CANOPEN_SEL(co_sel), .PIRQ_ACK(pirq_ack), .PIRQ_REQ(pirq_req),
    .PIRQ_EMCY(pirq_emcy), .PIRQ_DATA(pirq_data),
    .DIAG_INCOMING(diag_in), .DIAG_GOING(diag_go),
    .MODULE_FAULT_INDICATOR(fault));

  fci_host_model i_host (
    .clk(clock), .rec_num(rec_num), .rec_byte(rec_byte), .rec_wr(rec_wr),
    .rec_wdata(rec_wdata), .rec_rd(rec_rd), .rec_rdata(rec_rdata),
    .rec_rvalid(rec_rvalid), .rec_err(rec_err), .pirq_ack(pirq_ack));

  // Clock at 100 MHz
  always #5 clock = ~clock;

  // Cycles since release, and event pulse counts
  always @(posedge clock) begin
    cyc <= reset ? 0 : cyc + 1;
    if (diag_in === 1'b1) n_in <= n_in + 1;
    if (diag_go === 1'b1) n_go <= n_go + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle

  // Bounded wait for a pending interrupt, counting cycles
  task automatic wait_pend(output int n);
    n = 0;
    while (!(pirq_req === 1'b1 || pirq_emcy === 1'b1) && n < 2000) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_pend

  // Descriptor bytes, short record and unmapped access
  task automatic t_regs;
    logic [7:0] x [8] = '{8'h00, 8'h1f, 8'h00, 8'h00,
                          8'h70, 8'h00, 8'h04, 8'h00};
    for (int i = 0; i < 8; i++) begin
      i_host.rd(REC_PARAM1, 5'(i), d, e);
      chk(d, x[i]);
    end
    for (int i = 16; i < 20; i++) begin
      i_host.rd(REC_PARAM1, 5'(i), d, e);
      chk(d, 8'h00);
    end
    i_host.rd(REC_PARAM0, DB_MODINFO, d, e);
    chk(d, MODINFO_VAL);
    i_host.rd(8'h33, 5'h00, d, e);
    chk({e, d}, 9'h100);
  endtask : t_regs

  // Every delay code, then a pulse too short to pass
  task automatic t_filter;
    logic [7:0] code [6] = '{DLY_2US, DLY_4US, DLY_12US,
                             DLY_86US, DLY_342US, DLY_2731US};
    int lim [6] = '{200, 400, 1200, L86, L342, L2731};
    int n;
    i_host.wr(REC_EDGE, EB_RISE, 8'h02);
    foreach (code[i]) begin
      i_host.wr(REC_PARAM1, 5'h01, code[i]);
      in_ch[1] = 1'b1;
      wait_pend(n);
      chk(n >= lim[i] && n <= lim[i] + 8, 1);
      @(negedge clock);
      chk(in_state, 4'h2);
      chk(pirq_data[27:16], 12'h202);
      i_host.ack;
      in_ch[1] = 1'b0;
      idle(lim[i] + 20);
    end
    in_ch[1] = 1'b1;
    idle(L2731 - 30);
    in_ch[1] = 1'b0;
    idle(150);
    chk(pirq_req, 1'b0);
    chk(in_state, 4'h0);
  endtask : t_filter

  // Falling edge delivered as emergency, with timestamp
  task automatic t_emcy;
    logic [15:0] ets;
    int n;
    co_sel = 1'b1;
    i_host.wr(REC_PARAM1, 5'h02, DLY_2US);
    i_host.wr(REC_EDGE, EB_FALL, 8'h04);
    in_ch[2] = 1'b1;
    idle(300);
    chk({pirq_req, pirq_emcy}, 2'b00);
    in_ch[2] = 1'b0;
    wait_pend(n);
    chk({pirq_req, pirq_emcy}, 2'b01);
    @(negedge clock);
    ets = 16'(cyc / 100);
    chk(pirq_data[27:16], 12'h400);
    chk(pirq_data[15:0] - ets + 16'h1 <= 16'h2, 1);
    i_host.rd(REC_PROC_IRQ, PB_TS_HI, d, e);
    i_host.rd(REC_PROC_IRQ, PB_TS_LO, lo, e);
    chk({d, lo} - ets + 16'h1 <= 16'h2, 1);
    i_host.ack;
    co_sel = 1'b0;
  endtask : t_emcy

  // Lost edge with diagnostics off or on, edges inside the window
  task automatic t_loss(input logic [7:0] en);
    int n, i0, g0;
    logic on;
    on = (en == DIAGNOSTIC_ENABLE_ON);
    i0 = n_in;
    g0 = n_go;
    i_host.wr(REC_PARAM0, 5'h00, en);
    i_host.wr(REC_PARAM1, 5'h00, DLY_2US);
    i_host.wr(REC_EDGE, EB_RISE, 8'h03);
    in_ch[0] = 1'b1;
    wait_pend(n);
    in_ch[1] = 1'b1;
    idle(200);
    chk(pirq_data[27:24], 4'h1);
    chk(n_in - i0, on);
    chk(fault, on);
    i_host.rd(REC_PARAM1, DB_ERR_A, d, e);
    chk(d[0], on);
    in_ch[0] = 1'b0;
    idle(250);
    in_ch[0] = 1'b1;
    idle(250);
    i_host.rd(REC_PARAM1, DB_ERR_D, d, e);
    chk(d, on ? 8'h40 : 8'h48);
    i_host.rd(REC_PARAM1, DB_CHLOST, d, e);
    chk(d, on ? 8'h02 : 8'h03);
    i_host.ack;
    idle(4);
    chk(n_go - g0, on);
    chk(fault, 1'b0);
    in_ch = 4'h0;
    idle(300);
  endtask : t_loss

  task automatic final_report;
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // Watchdog, far beyond the expected run length
  initial begin
    #600000;
    fails++;
    final_report;
  end

  // Main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    in_ch = 4'h0;
    co_sel = 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    t_regs;
    t_filter;
    t_emcy;
    t_loss(DIAGNOSTIC_ENABLE_OFF);
    t_loss(DIAGNOSTIC_ENABLE_ON);
    final_report;
  end
endmodule : testbench
`default_nettype wire
